//--- design/ddc_chan_defines.svh
`ifndef DDC_CHAN_DEFINES_SVH
`define DDC_CHAN_DEFINES_SVH

// ==========================================
// Channel address map
`define A_SLEEP      8'h80
`define A_SOFT_TRIG  8'h81
`define A_PIN_TRIG   8'h82
`define A_START_DLY  8'h83
`define A_RETUNE_DLY 8'h84
`define A_FREQ_LO    8'h85
`define A_FREQ_HI    8'h86
`define A_PHASE      8'h87
`define A_OSC_CTRL   8'h88
`define A_RS_DEC     8'h90
`define A_RS_INTERP  8'h91
`define A_RS_SCALE   8'h92
`define A_RSVD_A     8'h93
`define A_C5_DEC     8'h94
`define A_C5_SCALE   8'h95
`define A_RSVD_B     8'h96
`define A_CF_DEC     8'hA0
`define A_CF_PHASE   8'hA1
`define A_CF_TAPS    8'hA2
`define A_CF_OFFSET  8'hA3
`define A_CF_CTRL    8'hA4
`define A_SIG_I      8'hA5
`define A_SIG_Q      8'hA6
`define A_SIG_COUNT  8'hA7
`define A_RAM_TEST   8'hA8
`define A_OUT_CTRL   8'hA9
`define COEF_WORDS   128

// ==========================================
// Field positions
`define OSC_SYNC_HI    8
`define OSC_SYNC_LO    7
`define OSC_PORT_B     6
`define OSC_CLR_HOP    3
`define OSC_AMP_DITH   2
`define OSC_PH_DITH    1
`define OSC_BYPASS     0
`define CF_BYP_TEST    10
`define CF_OTHER_SRC   9
`define CF_BANK        8
`define CF_COMMON_EXP  7
`define CF_FORCE_SCALE 6
`define OUT_MAP_SIG    9
`define OUT_WIDE       5

// ==========================================
// Reset values
`define RST_SLEEP  1'b1
`define RST_DELAY  16'h0001

`endif

//--- design/ddc_chan_pkg.sv
package ddc_chan_pkg;

	typedef enum logic [1:0] {FMT_FIXED, FMT_FLOAT8, FMT_FLOAT12} out_format_t;

	typedef struct packed {
		logic [1:0] sync_sel;
		logic       port_b;
		logic       clear_on_hop;
		logic       amp_dither;
		logic       phase_dither;
		logic       bypass;
	} osc_cfg_t;

	typedef struct packed {
		logic        test_bypass;
		logic        other_source;
		logic        ram_bank;
		logic        common_exp;
		logic        force_scale;
		out_format_t format;
		logic [3:0]  scale;
		logic [7:0]  taps_m1;
		logic [7:0]  decimation_m1;
		logic [7:0]  phase;
		logic [7:0]  coef_offset;
	} filt_cfg_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [19:0] wdata;
	} host_req_t;

endpackage

//--- design/ddc_chan_regs.sv
`timescale 1ns/100ps
`include "ddc_chan_defines.svh"

module ddc_chan_regs
	import ddc_chan_pkg::*;
#(
	parameter int DW = 20,
	parameter int AW = 8
) (
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	// Host access from the microport
	input  wire host_req_t     host_req,
	output logic [DW-1:0]      host_rdata,
	output logic               host_rvalid,
	// Global sleep write broadcast
	input  wire logic          glob_sleep_wr,
	input  wire logic          glob_sleep_val,
	// Pins from outside
	input  wire logic [3:0]    sync_pins,
	input  wire logic          level_pin,
	// Filter datapath status
	input  wire logic [15:0]   filt_out_i,
	input  wire logic [15:0]   filt_out_q,
	input  wire logic          filt_out_valid,
	input  wire logic          coef_ram_fail,
	input  wire logic          data_ram_fail,
	// Datapath steering
	output logic [31:0]        osc_freq,
	output logic [15:0]        osc_phase,
	output logic               osc_phase_clear,
	output osc_cfg_t           osc_cfg,
	output logic               chan_sleep,
	output logic [4:0]         resampler_scale,
	output filt_cfg_t          filt_cfg,
	output logic               wide_output,
	output logic               ram_test_en,
	// Coefficient RAM host port
	output logic               coef_wr,
	output logic [AW:0]        coef_addr,
	output logic [DW-1:0]      coef_wdata
);

	// ==========================================
	// Reset release
	logic rst_meta_q, rst_sync_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ==========================================
	// Pin synchronisers
	logic [3:0] sync_meta_q, sync_q, sync_prev_q;
	logic       level_meta_q, level_q;
	always_ff @(posedge core_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			sync_meta_q  <= 4'h0;
			sync_q       <= 4'h0;
			sync_prev_q  <= 4'h0;
			level_meta_q <= 1'b0;
			level_q      <= 1'b0;
		end else begin
			sync_meta_q  <= sync_pins;
			sync_q       <= sync_meta_q;
			sync_prev_q  <= sync_q;
			level_meta_q <= level_pin;
			level_q      <= level_meta_q;
		end
	end

	// ==========================================
	// Register storage
	logic        sleep_q;
	logic [2:0]  pin_trig_q;
	logic [15:0] start_dly_q, retune_dly_q, freq_lo_q, freq_hi_q, phase_q;
	logic [8:0]  osc_ctrl_q;
	logic [11:0] rs_dec_q, rs_scale_q;
	logic [8:0]  rs_interp_q;
	logic [7:0]  c5_dec_q, cf_dec_q, cf_phase_q, cf_taps_q, cf_off_q;
	logic [4:0]  c5_scale_q;
	logic [10:0] cf_ctrl_q;
	logic [15:0] sig_i_q, sig_q_q;
	logic [19:0] sig_cnt_q;
	logic        ram_en_q;
	logic [1:0]  ram_stat_q;
	logic [9:0]  out_ctrl_q;
	logic [31:0] work_freq_q;
	logic [15:0] retune_cnt_q, start_cnt_q;
	logic        retune_busy_q, start_busy_q, first_seen_q;
	wire logic [2:0] ram_test_q = {ram_stat_q, ram_en_q};

	// ==========================================
	// Decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	wire logic       wr = host_req.wr;
	wire logic [7:0] ad = host_req.addr;
	wire logic [19:0] wd = host_req.wdata;
	wire logic coef_hit = wr && !ad[7];

	// Selected sync pin, rising edge, gated by enables and first-only
	wire logic [1:0] sync_sel = osc_ctrl_q[`OSC_SYNC_HI:`OSC_SYNC_LO];
	wire logic pin_edge = sync_q[sync_sel] && !sync_prev_q[sync_sel];
	wire logic pin_ok   = pin_edge && !(pin_trig_q[2] && first_seen_q);
	wire logic pin_hop   = pin_ok && pin_trig_q[1];
	wire logic pin_start = pin_ok && pin_trig_q[0];
	wire logic soft_hop   = wr && hit(ad, `A_SOFT_TRIG) && wd[1];
	wire logic soft_start = wr && hit(ad, `A_SOFT_TRIG) && wd[0];
	wire logic hop_evt   = soft_hop || pin_hop;
	wire logic start_evt = soft_start || pin_start;

	// Delay value of zero disables; one acts at once
	wire logic hop_now   = hop_evt && (retune_dly_q == 16'h0001);
	wire logic hop_load  = hop_evt && (retune_dly_q > 16'h0001);
	wire logic hop_done  = retune_busy_q && (retune_cnt_q == 16'h0002);
	wire logic start_now  = start_evt && (start_dly_q == 16'h0001);
	wire logic start_load = start_evt && (start_dly_q > 16'h0001);
	wire logic start_done = start_busy_q && (start_cnt_q == 16'h0002);
	wire logic shadow_wr = wr && (hit(ad, `A_FREQ_LO) || hit(ad, `A_FREQ_HI));
	wire logic wake = sleep_q && (start_now || start_done);
	wire logic immed = shadow_wr && (retune_dly_q == 16'h0001);
	wire logic hop = hop_now || hop_done;
	// Merge the half being written, so an immediate copy never takes stale bits
	wire logic [15:0] lo_next = (wr && hit(ad, `A_FREQ_LO)) ? wd[15:0] : freq_lo_q;
	wire logic [15:0] hi_next = (wr && hit(ad, `A_FREQ_HI)) ? wd[15:0] : freq_hi_q;
	wire logic [31:0] shadow_word = {hi_next, lo_next};

	// ==========================================
	// Host writes
	always_ff @(posedge core_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			pin_trig_q   <= 3'h0;
			start_dly_q  <= `RST_DELAY;
			retune_dly_q <= `RST_DELAY;
			freq_lo_q    <= 16'h0000;
			freq_hi_q    <= 16'h0000;
			phase_q      <= 16'h0000;
			osc_ctrl_q   <= 9'h000;
			rs_dec_q     <= 12'h000;
			rs_interp_q  <= 9'h000;
			rs_scale_q   <= 12'h000;
			c5_dec_q     <= 8'h00;
			c5_scale_q   <= 5'h00;
			cf_dec_q     <= 8'h00;
			cf_phase_q   <= 8'h00;
			cf_taps_q    <= 8'h00;
			cf_off_q     <= 8'h00;
			cf_ctrl_q    <= 11'h000;
			out_ctrl_q   <= 10'h000;
			ram_en_q     <= 1'b0;
		end else if (wr) begin
			// Unmapped addresses simply match nothing
			if (hit(ad, `A_PIN_TRIG)) pin_trig_q <= wd[2:0];
			else if (hit(ad, `A_START_DLY)) start_dly_q <= wd[15:0];
			else if (hit(ad, `A_RETUNE_DLY)) retune_dly_q <= wd[15:0];
			else if (hit(ad, `A_FREQ_LO)) freq_lo_q <= wd[15:0];
			else if (hit(ad, `A_FREQ_HI)) freq_hi_q <= wd[15:0];
			else if (hit(ad, `A_PHASE)) phase_q <= wd[15:0];
			else if (hit(ad, `A_OSC_CTRL)) osc_ctrl_q <= wd[8:0];
			else if (hit(ad, `A_RS_DEC)) rs_dec_q <= wd[11:0];
			else if (hit(ad, `A_RS_INTERP)) rs_interp_q <= wd[8:0];
			else if (hit(ad, `A_RS_SCALE)) rs_scale_q <= wd[11:0];
			else if (hit(ad, `A_C5_DEC)) c5_dec_q <= wd[7:0];
			else if (hit(ad, `A_C5_SCALE)) c5_scale_q <= wd[4:0];
			else if (hit(ad, `A_CF_DEC)) cf_dec_q <= wd[7:0];
			else if (hit(ad, `A_CF_PHASE)) cf_phase_q <= wd[7:0];
			else if (hit(ad, `A_CF_TAPS)) cf_taps_q <= wd[7:0];
			else if (hit(ad, `A_CF_OFFSET)) cf_off_q <= wd[7:0];
			else if (hit(ad, `A_CF_CTRL)) cf_ctrl_q <= wd[10:0];
			else if (hit(ad, `A_RAM_TEST)) ram_en_q <= wd[0];
			else if (hit(ad, `A_OUT_CTRL)) out_ctrl_q <= wd[9:0];
		end
	end

	// ==========================================
	// Sleep flag, global broadcast then local override
	always_ff @(posedge core_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			sleep_q <= `RST_SLEEP;
		end else if (wake) begin
			sleep_q <= 1'b0;
		end else if (wr && hit(ad, `A_SLEEP)) begin
			sleep_q <= wd[0];
		end else if (glob_sleep_wr) begin
			sleep_q <= glob_sleep_val;
		end
	end

	// ==========================================
	// Hold-off counters and working frequency word
	always_ff @(posedge core_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			retune_cnt_q  <= 16'h0000;
			retune_busy_q <= 1'b0;
			start_cnt_q   <= 16'h0000;
			start_busy_q  <= 1'b0;
			first_seen_q  <= 1'b0;
			work_freq_q   <= 32'h0000_0000;
			osc_phase_clear <= 1'b0;
		end else begin
			// A sync landing with the rewrite still counts as seen
			if (wr && hit(ad, `A_PIN_TRIG)) first_seen_q <= 1'b0;
			if (pin_ok && |pin_trig_q[1:0]) first_seen_q <= 1'b1;
			if (hop_load) begin
				retune_cnt_q  <= retune_dly_q;
				retune_busy_q <= 1'b1;
			end else if (retune_busy_q) begin
				retune_cnt_q  <= retune_cnt_q - 16'h0001;
				retune_busy_q <= !hop_done;
			end
			if (start_load) begin
				start_cnt_q  <= start_dly_q;
				start_busy_q <= 1'b1;
			end else if (start_busy_q) begin
				start_cnt_q  <= start_cnt_q - 16'h0001;
				start_busy_q <= !start_done;
			end
			// Copy only on wake, finished hop, or immediate mode
			if (hop || wake || immed) work_freq_q <= shadow_word;
			osc_phase_clear <= hop && osc_ctrl_q[`OSC_CLR_HOP];
		end
	end

	// ==========================================
	// Signature capture and live output counter
	wire logic sig_take = filt_out_valid && (sig_cnt_q != 20'h00000);
	always_ff @(posedge core_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			sig_i_q   <= 16'h0000;
			sig_q_q   <= 16'h0000;
			sig_cnt_q <= 20'h00000;
			ram_stat_q <= 2'b00;
		end else begin
			ram_stat_q <= {data_ram_fail, coef_ram_fail};
			if (wr && hit(ad, `A_SIG_COUNT)) begin
				sig_cnt_q <= wd;
			end else if (sig_take) begin
				sig_cnt_q <= sig_cnt_q - 20'h00001;
			end
			if (filt_out_valid && out_ctrl_q[`OUT_MAP_SIG]) begin
				sig_i_q <= filt_out_i;
				sig_q_q <= filt_out_q;
			end else if (sig_take) begin
				// Rotate-and-fold signature
				sig_i_q <= {sig_i_q[14:0], sig_i_q[15]} ^ filt_out_i;
				sig_q_q <= {sig_q_q[14:0], sig_q_q[15]} ^ filt_out_q;
			end else begin
				if (wr && hit(ad, `A_SIG_I)) sig_i_q <= wd[15:0];
				if (wr && hit(ad, `A_SIG_Q)) sig_q_q <= wd[15:0];
			end
		end
	end

	// ==========================================
	// Read mux
	logic [19:0] rd_mux;
	assign rd_mux =
		hit(ad, `A_SLEEP)      ? {19'h0, sleep_q} :
		hit(ad, `A_PIN_TRIG)   ? {17'h0, pin_trig_q} :
		hit(ad, `A_START_DLY)  ? {4'h0, start_dly_q} :
		hit(ad, `A_RETUNE_DLY) ? {4'h0, retune_dly_q} :
		hit(ad, `A_FREQ_LO)    ? {4'h0, freq_lo_q} :
		hit(ad, `A_FREQ_HI)    ? {4'h0, freq_hi_q} :
		hit(ad, `A_PHASE)      ? {4'h0, phase_q} :
		hit(ad, `A_OSC_CTRL)   ? {11'h0, osc_ctrl_q} :
		hit(ad, `A_RS_DEC)     ? {8'h0, rs_dec_q} :
		hit(ad, `A_RS_INTERP)  ? {11'h0, rs_interp_q} :
		hit(ad, `A_RS_SCALE)   ? {8'h0, rs_scale_q} :
		hit(ad, `A_C5_DEC)     ? {12'h0, c5_dec_q} :
		hit(ad, `A_C5_SCALE)   ? {15'h0, c5_scale_q} :
		hit(ad, `A_CF_DEC)     ? {12'h0, cf_dec_q} :
		hit(ad, `A_CF_PHASE)   ? {12'h0, cf_phase_q} :
		hit(ad, `A_CF_TAPS)    ? {12'h0, cf_taps_q} :
		hit(ad, `A_CF_OFFSET)  ? {12'h0, cf_off_q} :
		hit(ad, `A_CF_CTRL)    ? {9'h0, cf_ctrl_q} :
		hit(ad, `A_SIG_I)      ? {4'h0, sig_i_q} :
		hit(ad, `A_SIG_Q)      ? {4'h0, sig_q_q} :
		hit(ad, `A_SIG_COUNT)  ? sig_cnt_q :
		hit(ad, `A_RAM_TEST)   ? {17'h0, ram_test_q} :
		hit(ad, `A_OUT_CTRL)   ? {10'h0, out_ctrl_q} :
		20'h00000;

	// Coefficient memory lives in the datapath; reads of it return zero here
	always_ff @(posedge core_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			host_rdata  <= 20'h00000;
			host_rvalid <= 1'b0;
			coef_wr     <= 1'b0;
			coef_addr   <= '0;
			coef_wdata  <= '0;
		end else begin
			host_rvalid <= host_req.rd;
			if (host_req.rd) host_rdata <= rd_mux;
			coef_wr    <= coef_hit;
			coef_addr  <= {cf_ctrl_q[`CF_BANK], 1'b0, ad[6:0]};
			coef_wdata <= wd;
		end
	end

	// ==========================================
	// Steering outputs
	always_ff @(posedge core_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			osc_freq        <= 32'h0000_0000;
			osc_phase       <= 16'h0000;
			osc_cfg         <= '0;
			chan_sleep      <= `RST_SLEEP;
			resampler_scale <= 5'h00;
			filt_cfg        <= '0;
			wide_output     <= 1'b0;
			ram_test_en     <= 1'b0;
		end else begin
			osc_freq  <= work_freq_q;
			osc_phase <= phase_q;
			osc_cfg.sync_sel     <= sync_sel;
			osc_cfg.port_b       <= osc_ctrl_q[`OSC_PORT_B];
			osc_cfg.clear_on_hop <= osc_ctrl_q[`OSC_CLR_HOP];
			osc_cfg.amp_dither   <= osc_ctrl_q[`OSC_AMP_DITH];
			osc_cfg.phase_dither <= osc_ctrl_q[`OSC_PH_DITH];
			osc_cfg.bypass       <= osc_ctrl_q[`OSC_BYPASS];
			chan_sleep <= sleep_q;
			resampler_scale <= level_q ? rs_scale_q[9:5] : rs_scale_q[4:0];
			filt_cfg.test_bypass  <= cf_ctrl_q[`CF_BYP_TEST];
			filt_cfg.other_source <= cf_ctrl_q[`CF_OTHER_SRC];
			filt_cfg.ram_bank     <= cf_ctrl_q[`CF_BANK];
			filt_cfg.common_exp   <= cf_ctrl_q[`CF_COMMON_EXP];
			filt_cfg.force_scale  <= cf_ctrl_q[`CF_FORCE_SCALE];
			filt_cfg.format <= cf_ctrl_q[5] ? FMT_FLOAT12 :
				(cf_ctrl_q[4] ? FMT_FLOAT8 : FMT_FIXED);
			filt_cfg.scale         <= cf_ctrl_q[3:0];
			filt_cfg.taps_m1       <= cf_taps_q;
			filt_cfg.decimation_m1 <= cf_dec_q;
			filt_cfg.phase         <= cf_phase_q;
			filt_cfg.coef_offset   <= cf_off_q;
			wide_output <= out_ctrl_q[`OUT_WIDE];
			ram_test_en <= ram_test_q[0];
		end
	end

endmodule // ddc_chan_regs

//--- verification/ddc_chan_props.sv
`timescale 1ns/100ps
`include "ddc_chan_defines.svh"
module ddc_chan_props
	import ddc_chan_pkg::*;
#(
	parameter int DW = 20,
	parameter int AW = 8
) (
	// Clock, reset and host side
	input wire logic          core_clk,
	input wire logic          rst_n,
	input wire host_req_t     host_req,
	input wire logic [DW-1:0] host_rdata,
	input wire logic          host_rvalid,
	// Steering outputs
	input wire logic          osc_phase_clear,
	input wire osc_cfg_t      osc_cfg,
	input wire filt_cfg_t     filt_cfg,
	input wire logic          wide_output,
	input wire logic          ram_test_en,
	input wire logic          coef_wr,
	input wire logic [AW:0]   coef_addr,
	input wire logic [DW-1:0] coef_wdata
);
	// ==========================================
	// Decode of the request
	wire logic [7:0] a = host_req.addr;
	wire logic       w = host_req.wr;
	wire logic       hole = a == `A_RSVD_A || a == `A_RSVD_B || (a > 8'h88 && a < 8'h90)
		|| (a > 8'h96 && a < 8'hA0) || a > `A_OUT_CTRL;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ==========================================
	// Properties
	a_read_answer: assert property (host_req.rd |=> host_rvalid)
		else $error("read got no answer");
	a_answer_cause: assert property (host_rvalid |-> $past(host_req.rd))
		else $error("answer without a read");
	a_osc_fields: assert property (w && a == `A_OSC_CTRL |-> ##2
		osc_cfg == {$past(host_req.wdata[8:6], 2), $past(host_req.wdata[3:0], 2)})
		else $error("oscillator control fields wrong");
	a_taps_load: assert property (w && a == `A_CF_TAPS |-> ##2
		filt_cfg.taps_m1 == $past(host_req.wdata[7:0], 2)) else $error("tap count wrong");
	a_filt_bits: assert property (w && a == `A_CF_CTRL |-> ##2
		{filt_cfg.test_bypass, filt_cfg.other_source, filt_cfg.ram_bank, filt_cfg.common_exp,
		filt_cfg.force_scale, filt_cfg.scale} ==
		{$past(host_req.wdata[10:6], 2), $past(host_req.wdata[3:0], 2)})
		else $error("filter control bits wrong");
	a_out_format: assert property (w && a == `A_CF_CTRL |-> ##2
		filt_cfg.format == ($past(host_req.wdata[5], 2) ? FMT_FLOAT12 :
		$past(host_req.wdata[4], 2) ? FMT_FLOAT8 : FMT_FIXED)) else $error("format wrong");
	a_wide_sel: assert property (w && a == `A_OUT_CTRL |-> ##2
		wide_output == $past(host_req.wdata[5], 2)) else $error("word width wrong");
	a_ramtest_en: assert property (w && a == `A_RAM_TEST |-> ##2
		ram_test_en == $past(host_req.wdata[0], 2)) else $error("RAM test enable wrong");
	a_hole_zero: assert property (host_req.rd && hole |=> host_rdata == '0)
		else $error("unused address read nonzero");
	a_clear_gate: assert property (osc_phase_clear |-> osc_cfg.clear_on_hop)
		else $error("phase cleared while disabled");
	a_coef_port: assert property (w && !a[7] |=> coef_wr &&
		coef_addr[6:0] == $past(a[6:0]) && coef_wdata == $past(host_req.wdata))
		else $error("coefficient write wrong");
endmodule // ddc_chan_props

bind ddc_chan_regs ddc_chan_props #(.DW(DW), .AW(AW)) props_u (.core_clk, .rst_n,
	.host_req, .host_rdata, .host_rvalid, .osc_phase_clear, .osc_cfg, .filt_cfg,
	.wide_output, .ram_test_en, .coef_wr, .coef_addr, .coef_wdata);

//--- verification/ddc_channel_config_map_bench.sv
`timescale 1ns/100ps
module ddc_channel_config_map_bench;
	import ddc_chan_pkg::*;

	logic core_clk, rst_n, host_rvalid, glob_sleep_wr, glob_sleep_val, level_pin;
	logic filt_out_valid, coef_ram_fail, data_ram_fail, osc_phase_clear, chan_sleep;
	logic wide_output, ram_test_en, coef_wr;
	logic [3:0]  sync_pins;
	logic [4:0]  resampler_scale;
	logic [8:0]  coef_addr, coef_seen;
	logic [15:0] filt_out_i, filt_out_q, osc_phase;
	logic [19:0] host_rdata, coef_wdata;
	logic [31:0] osc_freq;
	host_req_t   host_req;
	osc_cfg_t    osc_cfg;
	filt_cfg_t   filt_cfg;
	int          n_mismatch, comparisons, n_clear;

	ddc_chan_regs dut_u (.core_clk, .rst_n, .host_req, .host_rdata, .host_rvalid,
		.glob_sleep_wr, .glob_sleep_val, .sync_pins, .level_pin, .filt_out_i, .filt_out_q,
		.filt_out_valid, .coef_ram_fail, .data_ram_fail, .osc_freq, .osc_phase,
		.osc_phase_clear, .osc_cfg, .chan_sleep, .resampler_scale, .filt_cfg, .wide_output,
		.ram_test_en, .coef_wr, .coef_addr, .coef_wdata);
	ddc_host_model host_u (.core_clk, .host_req, .host_rdata, .host_rvalid);

	initial begin
		core_clk = 0;
		forever #4 core_clk = ~core_clk;
	end

	// Pulse outputs are caught here, not polled
	always @(posedge core_clk) begin
		if (coef_wr === 1'b1) coef_seen <= coef_addr;
		if (osc_phase_clear === 1'b1) n_clear <= n_clear + 1;
	end

	// ==========================================
	// Checking helpers
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [19:0] e);
		logic [19:0] d;
		bit ok;
		host_u.read(a, d, ok);
		chk({nm, " answer"}, 1, ok);
		chk(nm, e, d);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic pulse_pin(input logic [3:0] p);
		sync_pins <= p;
		wait_cyc(3);
		sync_pins <= 4'h0;
		wait_cyc(12);
	endtask

	task automatic give_verdict();
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ==========================================
	// Register table: all ones written, except bits 5:4 at 8'h88 and 11:10 at 8'h92 that the host model masks; width and holes read back
	logic [7:0]  t_adr [17] = '{8'h87, 8'h88, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96,
		8'h8A, 8'h9F, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hAA};
	logic [19:0] t_exp [17] = '{20'h0FFFF, 20'h001CF, 20'h00FFF, 20'h001FF, 20'h003FF, 20'h0,
		20'h000FF, 20'h0001F, 20'h0, 20'h0, 20'h0, 20'h000FF, 20'h000FF, 20'h000FF, 20'h000FF,
		20'h007FF, 20'h0};

	initial begin
		#200000;
		n_mismatch++;
		give_verdict();
	end

	initial begin
		{rst_n, glob_sleep_wr, glob_sleep_val, level_pin, filt_out_valid} = '0;
		{coef_ram_fail, data_ram_fail, sync_pins, filt_out_i, filt_out_q} = '0;
		{n_mismatch, comparisons, n_clear} = '0;
		coef_seen = '0;
		wait_cyc(2);
		rst_n <= 1'b1;
		wait_cyc(4);
		chk("sleep reset", 1, chan_sleep);
		rd_chk("start delay reset", 8'h83, 20'h00001);
		rd_chk("retune delay reset", 8'h84, 20'h00001);
		foreach (t_adr[i]) host_u.write(t_adr[i], 20'hFFFFF);
		foreach (t_adr[i]) rd_chk("readback", t_adr[i], t_exp[i]);
		// Delay of one: shadow goes straight through
		host_u.write(8'h85, 20'h01234);
		host_u.write(8'h86, 20'h0ABCD);
		wait_cyc(3);
		chk("freq immediate", 32'hABCD1234, osc_freq);
		// Software hop with delay four, phase clear on
		host_u.write(8'h84, 20'h00004);
		host_u.write(8'h85, 20'h05678);
		host_u.write(8'h86, 20'h00000);
		host_u.write(8'h88, 20'h00008);
		wait_cyc(4);
		chk("freq held", 32'hABCD1234, osc_freq);
		host_u.write(8'h81, 20'h00002);
		wait_cyc(1);
		chk("freq delayed", 32'hABCD1234, osc_freq);
		wait_cyc(8);
		chk("freq hopped", 32'h00005678, osc_freq);
		chk("phase clears", 1, n_clear);
		// Pin hop on pin C; pin A must not act
		host_u.write(8'h88, 20'h00100);
		host_u.write(8'h82, 20'h00002);
		host_u.write(8'h86, 20'h01111);
		pulse_pin(4'h1);
		chk("wrong pin", 32'h00005678, osc_freq);
		pulse_pin(4'h4);
		chk("pin hop", 32'h11115678, osc_freq);
		chk("no clear", 1, n_clear);
		// First sync only: a second pulse must not hop
		host_u.write(8'h82, 20'h00006);
		host_u.write(8'h86, 20'h02222);
		pulse_pin(4'h4);
		chk("first sync", 32'h22225678, osc_freq);
		host_u.write(8'h86, 20'h03333);
		pulse_pin(4'h4);
		chk("later sync", 32'h22225678, osc_freq);
		// Software start, then global sleep and local wake
		host_u.write(8'h83, 20'h00003);
		host_u.write(8'h81, 20'h00001);
		chk("still asleep", 1, chan_sleep);
		wait_cyc(8);
		chk("started", 0, chan_sleep);
		chk("wake copy", 32'h33335678, osc_freq);
		glob_sleep_val <= 1'b1;
		glob_sleep_wr <= 1'b1;
		wait_cyc(1);
		glob_sleep_wr <= 1'b0;
		wait_cyc(3);
		chk("global sleep", 1, chan_sleep);
		host_u.write(8'h80, 20'h00000);
		wait_cyc(3);
		chk("local wake", 0, chan_sleep);
		// Level pin picks the scale half
		host_u.write(8'h92, 20'h002AA);
		wait_cyc(6);
		chk("scale inactive", 5'h0A, resampler_scale);
		level_pin <= 1'b1;
		wait_cyc(6);
		chk("scale active", 5'h15, resampler_scale);
		// Raw capture of two samples into the signatures
		host_u.write(8'hA9, 20'h00220);
		host_u.write(8'hA7, 20'h00002);
		@(posedge core_clk) {filt_out_valid, filt_out_i, filt_out_q} <= {1'b1, 32'h13572468};
		@(posedge core_clk) {filt_out_i, filt_out_q} <= 32'h9ABCDEF0;
		@(posedge core_clk) filt_out_valid <= 1'b0;
		wait_cyc(2);
		rd_chk("sig inphase", 8'hA5, 20'h09ABC);
		rd_chk("sig quadrature", 8'hA6, 20'h0DEF0);
		rd_chk("sig count", 8'hA7, 20'h00000);
		// Folded signature of one sample over seeded registers
		host_u.write(8'hA9, 20'h00020);
		host_u.write(8'hA5, 20'h00001);
		host_u.write(8'hA6, 20'h08000);
		host_u.write(8'hA7, 20'h00001);
		@(posedge core_clk) {filt_out_valid, filt_out_i, filt_out_q} <= {1'b1, 32'h12340F0F};
		@(posedge core_clk) filt_out_valid <= 1'b0;
		wait_cyc(2);
		rd_chk("sig fold inphase", 8'hA5, 20'h01236);
		rd_chk("sig fold quadrature", 8'hA6, 20'h00F0E);
		rd_chk("sig fold count", 8'hA7, 20'h00000);
		// RAM test status and coefficient bank
		coef_ram_fail <= 1'b1;
		host_u.write(8'hA8, 20'h00001);
		rd_chk("ram test", 8'hA8, 20'h00003);
		host_u.write(8'h05, 20'hABCDE);
		wait_cyc(3);
		chk("coef bank", 9'h105, coef_seen);
		give_verdict();
	end
endmodule // ddc_channel_config_map_bench

//--- verification/ddc_host_model.sv
`timescale 1ns/100ps
`include "ddc_chan_defines.svh"
module ddc_host_model
	import ddc_chan_pkg::*;
(
	// Microport side
	input  wire logic        core_clk,
	output host_req_t        host_req,
	input  wire logic [19:0] host_rdata,
	input  wire logic        host_rvalid
);
	initial host_req = '0;

	// ==========================================
	// One-cycle strobes, released on the edge that takes them
	task automatic write(input logic [7:0] adr, input logic [19:0] d);
		logic [19:0] m;
		m = adr == `A_RS_SCALE ? d & 20'hFF3FF : adr == `A_OSC_CTRL ? d & 20'hFFFCF : d;
		@(posedge core_clk) host_req <= '{wr: 1'b1, rd: 1'b0, addr: adr, wdata: m};
		@(posedge core_clk) host_req <= '0;
	endtask

	task automatic read(input logic [7:0] adr, output logic [19:0] d, output bit ok);
		ok = 0;
		d = 'x;
		@(posedge core_clk) host_req <= '{wr: 1'b0, rd: 1'b1, addr: adr, wdata: 20'h00000};
		@(posedge core_clk) host_req <= '0;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge core_clk);
			if (host_rvalid === 1'b1) begin
				ok = 1;
				d = host_rdata;
			end
		end
	endtask
endmodule // ddc_host_model
